// ==== core/aacq_pkg.sv ====
// Purpose: shared constants and carriers for the acquisition control block
// Assumes: one clock, clk_sys at 10 MHz
// Notes:   result word layout, interrupt source codes, counter modes
package aacq_pkg;

    // ------------------------------------------------------------
    // result word layout
    // ------------------------------------------------------------
    localparam int AACQ_VALUE_LSB   = 0;
    localparam int AACQ_VALUE_W     = 12;
    localparam int AACQ_CHAN_LSB    = 16;
    localparam int AACQ_CHAN_W      = 5;
    localparam int AACQ_WORD_W      = 32;
    localparam int AACQ_FIFO_DEPTH  = 1024;
    localparam int AACQ_BLOCK_WORDS = 512;

    // ------------------------------------------------------------
    // interrupt source codes
    // ------------------------------------------------------------
    localparam logic [1:0] AACQ_IRQ_OFF       = 2'h0;
    localparam logic [1:0] AACQ_IRQ1_EOC      = 2'h1;
    localparam logic [1:0] AACQ_IRQ1_HALF     = 2'h2;
    localparam logic [1:0] AACQ_IRQ2_PACER    = 2'h1;
    localparam logic [1:0] AACQ_IRQ2_EXTERNAL = 2'h2;

    // ------------------------------------------------------------
    // timer channels and counter modes
    // ------------------------------------------------------------
    localparam logic [1:0] AACQ_TMR_GENERAL = 2'h0;
    localparam logic [1:0] AACQ_TMR_PACER_A = 2'h1;
    localparam logic [1:0] AACQ_TMR_PACER_B = 2'h2;
    localparam logic [2:0] AACQ_MODE_ONESHOT = 3'h1;
    localparam logic [2:0] AACQ_MODE_RATE    = 3'h2;
    localparam logic [2:0] AACQ_MODE_SQUARE  = 3'h3;
    localparam logic [2:0] AACQ_MODE_SW_STB  = 3'h4;
    localparam logic [2:0] AACQ_MODE_HW_STB  = 3'h5;

    // ------------------------------------------------------------
    // reset values and conversion timing
    // ------------------------------------------------------------
    localparam logic [15:0] AACQ_DIV_RESET   = 16'h0000;
    localparam int          AACQ_CONV_NS     = 1000;
    localparam int          AACQ_CLK_NS      = 100;
    localparam int          AACQ_CONV_CYCLES = (AACQ_CONV_NS + AACQ_CLK_NS - 1) / AACQ_CLK_NS;

    // one finished conversion
    typedef struct packed {
        logic [AACQ_CHAN_W-1:0]  chan;
        logic [AACQ_VALUE_W-1:0] value;
    } aacq_sample_t;

    // fifo status flags and converter busy
    typedef struct packed {
        logic empty;
        logic half;
        logic full;
        logic busy;
    } aacq_status_t;

    function automatic logic [AACQ_WORD_W-1:0] aacq_pack(input aacq_sample_t s);
        logic [AACQ_WORD_W-1:0] w;
        w = '0;
        w[AACQ_VALUE_LSB +: AACQ_VALUE_W] = s.value;
        w[AACQ_CHAN_LSB +: AACQ_CHAN_W]   = s.chan;
        return w;
    endfunction

endpackage

// ==== core/aacq_skid.sv ====
// Purpose: two-entry buffer between the converter and the result fifo
// Assumes: same clock on both sides
// Notes:   a stall downstream loses no stored word; a word offered while both slots are full is not taken
module aacq_skid #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             flush,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot [2];
    logic             rd_ptr;
    logic             wr_ptr;
    logic [1:0]       count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // ready as long as a slot is free
    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = slot[rd_ptr];

    // pointers and occupancy
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (flush) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop)  rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage needs no reset
    always_ff @(posedge clk_sys) begin
        if (push) slot[wr_ptr] <= in_data;
    end
endmodule

// ==== core/aacq_counter.sv ====
// Purpose: one programmable down counter with six operating modes
// Assumes: count enable pulses come from the owner's clock domain
// Notes:   a count of zero leaves the counter disarmed, so it does not count
module aacq_counter #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // control
    input  wire logic             load,
    input  wire logic [2:0]       mode,
    input  wire logic [WIDTH-1:0] value,
    input  wire logic             tick,
    input  wire logic             gate_rise,
    // state
    output logic      [WIDTH-1:0] count,
    output logic                  out,
    output logic                  terminal
);
    import aacq_pkg::*;
    logic             armed;
    logic [WIDTH-1:0] reload;
    logic [2:0]       mode_q;
    wire  [WIDTH-1:0] dec_step = (mode_q == AACQ_MODE_SQUARE) ? WIDTH'(2) : WIDTH'(1);
    wire              at_end   = (count <= dec_step) && armed && tick;
    wire              periodic = (mode_q == AACQ_MODE_RATE) || (mode_q == AACQ_MODE_SQUARE);
    wire              gated    = (mode_q == AACQ_MODE_ONESHOT) || (mode_q == AACQ_MODE_HW_STB);

    assign terminal = at_end;

    // counting engine; a zero reload in one-shot leaves the output idle high
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count  <= '0;
            reload <= '0;
            mode_q <= AACQ_MODE_ONESHOT;
            armed  <= 1'b0;
            out    <= 1'b1;
        end else if (load) begin
            count  <= value;
            reload <= value;
            mode_q <= mode;
            armed  <= (value != '0) && !((mode == AACQ_MODE_ONESHOT) || (mode == AACQ_MODE_HW_STB));
            out    <= (mode != 3'h0);
        end else if (gated && gate_rise && reload != '0) begin
            count <= reload;
            armed <= 1'b1;
            out   <= (mode_q != AACQ_MODE_ONESHOT);
        end else if (tick && armed) begin
            if (at_end) begin
                count <= periodic ? reload : '0;
                armed <= periodic;
                case (mode_q)
                    AACQ_MODE_SQUARE: out <= ~out;
                    AACQ_MODE_RATE:   out <= 1'b1;
                    3'h0:             out <= 1'b1;
                    default:          out <= 1'b1;
                endcase
            end else begin
                count <= count - dec_step;
                if (mode_q == AACQ_MODE_RATE && count == WIDTH'(2)) out <= 1'b0;
                if ((mode_q == AACQ_MODE_SW_STB || mode_q == AACQ_MODE_HW_STB) && count == WIDTH'(2))
                    out <= 1'b0;
            end
        end else if (mode_q == AACQ_MODE_SW_STB || mode_q == AACQ_MODE_HW_STB) begin
            out <= 1'b1;
        end
    end
endmodule

// ==== core/aacq_top.sv ====
// Purpose: acquisition control: triggers, result fifo, timers, interrupts
// Assumes: converter front end hands back one sample per trigger
// Notes:   control bits are plain ports, no register bus
// ------------------------------------------------------------
// top module
// ------------------------------------------------------------
module aacq_top #(
    parameter int DEPTH = aacq_pkg::AACQ_FIFO_DEPTH,
    parameter int HALF  = aacq_pkg::AACQ_BLOCK_WORDS
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    // trigger control
    input  wire logic                    soft_trigger,
    input  wire logic                    pacer_select,
    input  wire logic                    fifo_reset,
    // converter front end
    output logic                         conv_start,
    input  wire logic                    conv_done,
    input  wire aacq_pkg::aacq_sample_t  conv_sample,
    // result read port
    input  wire logic                    result_read,
    output logic [31:0]                  result_word,
    output logic                         result_valid,
    output aacq_pkg::aacq_status_t       status,
    // timer access
    input  wire logic [1:0]              timer_channel_index,
    input  wire logic                    timer_write,
    input  wire logic [7:0]              timer_write_byte,
    input  wire logic                    timer_byte_high,
    input  wire logic                    timer_read,
    output logic [7:0]                   timer_read_byte,
    // general counter
    input  wire logic                    counter_start,
    input  wire logic                    counter_stop,
    input  wire logic [2:0]              counter_operating_mode,
    input  wire logic [15:0]             general_counter_value,
    input  wire logic                    counter_ext_select,
    input  wire logic                    counter_ext_clock,
    input  wire logic                    counter_ext_gate,
    output logic [15:0]                  counter_readback,
    output logic                         counter_out,
    // interrupts
    input  wire logic [1:0]              first_irq_source_select,
    input  wire logic [1:0]              second_irq_source_select,
    input  wire logic                    irq_clear,
    input  wire logic                    ext_irq_in,
    output logic                         first_interrupt_line,
    output logic                         second_interrupt_line
);
    import aacq_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync_clk;
    logic [1:0] sync_gate;
    logic [1:0] sync_irq;
    logic       prev_clk;
    logic       prev_gate;
    logic       prev_irq;

    // first stage is only read by the second
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_clk  <= 2'h0;
            sync_gate <= 2'h0;
            sync_irq  <= 2'h0;
            prev_clk  <= 1'b0;
            prev_gate <= 1'b0;
            prev_irq  <= 1'b0;
        end else begin
            sync_clk  <= {sync_clk[0], counter_ext_clock};
            sync_gate <= {sync_gate[0], counter_ext_gate};
            sync_irq  <= {sync_irq[0], ext_irq_in};
            prev_clk  <= sync_clk[1];
            prev_gate <= sync_gate[1];
            prev_irq  <= sync_irq[1];
        end
    end

    wire ext_clk_rise  = sync_clk[1] && !prev_clk;
    wire ext_gate_rise = sync_gate[1] && !prev_gate;
    wire ext_irq_rise  = sync_irq[1] && !prev_irq;

    // ------------------------------------------------------------
    // timer channels
    // ------------------------------------------------------------
    logic [15:0] div_a;
    logic [15:0] div_b;
    logic [7:0]  low_byte;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [15:0] cnt_g;
    logic        tick_a;
    logic        tick_b;
    logic        out_g;

    // byte writes: low byte is held, high byte completes the load
    wire        wr_hi  = timer_write && timer_byte_high;
    wire [15:0] wr_val = {timer_write_byte, low_byte};
    wire        load_a = wr_hi && (timer_channel_index == AACQ_TMR_PACER_A);
    wire        load_b = wr_hi && (timer_channel_index == AACQ_TMR_PACER_B);
    wire        load_g = (wr_hi && (timer_channel_index == AACQ_TMR_GENERAL))
                         || counter_start || counter_stop;
    wire [2:0]  mode_g = counter_stop ? AACQ_MODE_ONESHOT : counter_operating_mode;
    wire [15:0] val_g  = counter_stop ? 16'h0000
                         : (counter_start ? general_counter_value : wr_val);
    wire        tick_g = counter_ext_select ? ext_clk_rise : 1'b1;
    wire        pacer_on = (div_a != 16'h0000) && (div_b != 16'h0000);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            div_a    <= AACQ_DIV_RESET;
            div_b    <= AACQ_DIV_RESET;
            low_byte <= 8'h00;
        end else begin
            if (timer_write && !timer_byte_high) low_byte <= timer_write_byte;
            if (load_a) div_a <= wr_val;
            if (load_b) div_b <= wr_val;
        end
    end

    // divider a runs on the system clock and feeds divider b
    aacq_counter #(.WIDTH(16)) u_pacer_a (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .load      (load_a),
        .mode      (AACQ_MODE_RATE),
        .value     (wr_val),
        .tick      (1'b1),
        .gate_rise (1'b0),
        .count     (cnt_a),
        .out       (),
        .terminal  (tick_a)
    );

    aacq_counter #(.WIDTH(16)) u_pacer_b (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .load      (load_b),
        .mode      (AACQ_MODE_RATE),
        .value     (wr_val),
        .tick      (tick_a),
        .gate_rise (1'b0),
        .count     (cnt_b),
        .out       (),
        .terminal  (tick_b)
    );

    aacq_counter #(.WIDTH(16)) u_general (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .load      (load_g),
        .mode      (mode_g),
        .value     (val_g),
        .tick      (tick_g),
        .gate_rise (ext_gate_rise),
        .count     (cnt_g),
        .out       (out_g),
        .terminal  ()
    );

    // read byte: only the low eight bits of the selected count
    wire [7:0] sel_byte = (timer_channel_index == AACQ_TMR_PACER_A) ? cnt_a[7:0]
                        : (timer_channel_index == AACQ_TMR_PACER_B) ? cnt_b[7:0]
                        : cnt_g[7:0];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            timer_read_byte  <= 8'h00;
            counter_readback <= 16'h0000;
            counter_out      <= 1'b1;
        end else begin
            if (timer_read) timer_read_byte <= sel_byte;
            counter_readback <= cnt_g;
            counter_out      <= out_g;
        end
    end

    // ------------------------------------------------------------
    // trigger and conversion sequencing
    // ------------------------------------------------------------
    wire pacer_tick = tick_b && pacer_on;
    wire trig       = soft_trigger || (pacer_select && pacer_tick);
    logic busy;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            conv_start <= 1'b0;
            busy       <= 1'b0;
        end else begin
            conv_start <= trig && !busy;
            if (trig && !busy) busy <= 1'b1;
            else if (conv_done) busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // result path: skid buffer then fifo
    // ------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);
    logic [31:0] mem [DEPTH];
    logic [AW:0] level;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic        lost;
    logic        sk_valid;
    logic        sk_ready;
    logic [31:0] sk_data;

    aacq_skid #(.WIDTH(32)) u_skid (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .flush     (fifo_reset),
        .in_valid  (conv_done),
        .in_ready  (),
        .in_data   (aacq_pack(conv_sample)),
        .out_valid (sk_valid),
        .out_ready (sk_ready),
        .out_data  (sk_data)
    );

    wire fifo_full  = (level == (AW+1)'(DEPTH));
    wire fifo_empty = (level == '0);
    wire do_pop     = result_read && !fifo_empty;
    assign sk_ready = !fifo_full;
    wire do_push    = sk_valid && sk_ready;
    wire drop       = conv_done && fifo_full;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            level  <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            lost   <= 1'b0;
        end else if (fifo_reset) begin
            level  <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            lost   <= 1'b0;
        end else begin
            if (do_push) wr_ptr <= wr_ptr + 1'b1;
            if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
            level <= level + (AW+1)'(do_push) - (AW+1)'(do_pop);
            if (drop) lost <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (do_push) mem[wr_ptr] <= sk_data;
    end

    wire [AW:0] next_level = fifo_reset ? '0
                           : level + (AW+1)'(do_push) - (AW+1)'(do_pop);

    // empty and half follow the level, full also latches a lost word; reset empties them in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            result_word  <= 32'h00000000;
            result_valid <= 1'b0;
            status       <= '{empty: 1'b1, half: 1'b0, full: 1'b0, busy: 1'b0};
        end else begin
            result_valid <= do_pop && !fifo_reset;
            if (do_pop) result_word <= mem[rd_ptr];
            status.empty <= (next_level == '0);
            status.half  <= (next_level >= (AW+1)'(HALF));
            status.full  <= (next_level == (AW+1)'(DEPTH)) || (lost && !fifo_reset);
            status.busy  <= busy;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire half_rise = status.half == 1'b0 && next_level >= (AW+1)'(HALF) && !fifo_reset;
    wire src1 = (first_irq_source_select == AACQ_IRQ1_EOC  && do_push)
             || (first_irq_source_select == AACQ_IRQ1_HALF && half_rise);
    wire src2 = (second_irq_source_select == AACQ_IRQ2_PACER    && pacer_tick)
             || (second_irq_source_select == AACQ_IRQ2_EXTERNAL && ext_irq_rise);

    // request stays until cleared; a new event on the clear cycle still wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            first_interrupt_line  <= 1'b0;
            second_interrupt_line <= 1'b0;
        end else begin
            first_interrupt_line  <= src1 || (first_interrupt_line && !irq_clear);
            second_interrupt_line <= src2 || (second_interrupt_line && !irq_clear);
        end
    end
endmodule

// ==== bench/aacq_top_assertions.sv ====
// Purpose: port checks for aacq_top
// Assumes: one clock, async reset high
// Notes:   bound to every aacq_top
module aacq_chk #(
    parameter int DEPTH = 1024,
    parameter int HALF  = 512
) (
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   reset,
    // triggers and fifo
    input wire logic                   soft_trigger,
    input wire logic                   fifo_reset,
    input wire logic                   conv_start,
    input wire logic                   result_read,
    input wire logic                   result_valid,
    input wire logic [31:0]            result_word,
    input wire aacq_pkg::aacq_status_t status,
    // counter and interrupt
    input wire logic                   counter_stop,
    input wire logic                   counter_out,
    input wire logic [1:0]             first_irq_source_select,
    input wire logic                   irq_clear,
    input wire logic                   first_interrupt_line
);
    import aacq_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // busy status lags the start by a cycle, so a start in flight is excluded
    property p_trig; soft_trigger && !status.busy && !conv_start |=> conv_start; endproperty
    a_trig: assert property (p_trig) else $error("trigger lost");
    property p_once; conv_start |=> !conv_start; endproperty
    a_once: assert property (p_once) else $error("start too long");
    property p_flush; fifo_reset |=> status.empty && !status.half && !status.full; endproperty
    a_flush: assert property (p_flush) else $error("flush flags");
    property p_pop; result_valid |-> $past(result_read); endproperty
    a_pop: assert property (p_pop) else $error("word without pop");
    property p_word; result_valid |-> result_word[15:12] == 4'h0 && result_word[31:21] == 11'h000; endproperty
    a_word: assert property (p_word) else $error("word layout");
    property p_stop; counter_stop |-> ##[1:2] counter_out; endproperty
    a_stop: assert property (p_stop) else $error("stop output low");
    property p_hold; first_interrupt_line && !irq_clear |=> first_interrupt_line; endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_off; $rose(first_interrupt_line) |-> $past(first_irq_source_select) != AACQ_IRQ_OFF; endproperty
    a_off: assert property (p_off) else $error("disabled source fired");
    cover property (conv_start);
    cover property (status.half);
    cover property ($rose(first_interrupt_line));
endmodule

bind aacq_top aacq_chk #(.DEPTH(DEPTH), .HALF(HALF)) u_chk (.*);

// ==== bench/aacq_conv_model.sv ====
// Purpose: converter front end model
// Assumes: one sample per start, fixed latency
// Notes:   idle sample lines show inverted data so stale reads fail
module aacq_conv_model #(
    parameter int LAT = 4
) (
    // clock and reset
    input  wire logic           clk_sys,
    input  wire logic           reset,
    // converter handshake
    input  wire logic           conv_start,
    output logic                conv_done,
    output aacq_pkg::aacq_sample_t conv_sample
);
    logic [7:0]  wait_cnt;
    logic [4:0]  seq;
    logic [16:0] word;
    // count down the conversion time, then step the channel
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wait_cnt <= 8'h00;
            seq <= 5'h00;
        end else if (conv_start) begin
            wait_cnt <= LAT[7:0];
        end else if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
            if (wait_cnt == 8'h01) seq <= seq + 5'h01;
        end
    end
    // sample value tracks the channel so each word is unique
    assign word = {seq, 7'h51, seq};
    assign conv_done = (wait_cnt == 8'h01);
    assign conv_sample = conv_done ? word : ~word;
endmodule

// ==== bench/test_adc_acquisition_control.sv ====
// Purpose: self-checking bench for aacq_top
// Assumes: small fifo, depth 16, half 8
// Notes:   external counter pins tied low
module test_adc_acquisition_control;
    timeunit 1ns;
    timeprecision 1ns;
    import aacq_pkg::*;
    typedef struct packed { logic [1:0] src; logic irq; logic [31:0] word; } aacq_row_t;
    localparam aacq_row_t ROWS [4] = '{{2'h0, 1'b0, 32'h00000A20}, {2'h1, 1'b1, 32'h00010A21},
                                       {2'h2, 1'b0, 32'h00020A22}, {2'h1, 1'b1, 32'h00030A23}};
    logic clk_sys = 1'b0, reset = 1'b1, soft_trigger = 1'b0, pacer_select = 1'b0, fifo_reset = 1'b0;
    logic result_read = 1'b0, timer_write = 1'b0, timer_byte_high = 1'b0, timer_read = 1'b0;
    logic counter_start = 1'b0, counter_stop = 1'b0, irq_clear = 1'b0, ext_irq_in = 1'b0;
    logic counter_ext_select = 1'b0, counter_ext_clock = 1'b0, counter_ext_gate = 1'b0;
    logic [1:0] timer_channel_index = 2'h0, first_irq_source_select = 2'h0, second_irq_source_select = 2'h0;
    logic [7:0] timer_write_byte = 8'h00, timer_read_byte;
    logic [2:0] counter_operating_mode = 3'h0;
    logic [15:0] general_counter_value = 16'h0000, counter_readback;
    logic conv_start, conv_done, result_valid, counter_out, first_interrupt_line, second_interrupt_line;
    logic [31:0] result_word;
    aacq_sample_t conv_sample;
    aacq_status_t status;
    int fail_count = 0, tests_run = 0, n;
    aacq_top #(.DEPTH(16), .HALF(8)) i_dut (.*);
    aacq_conv_model u_conv (.*);
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    // soft trigger, wait for the model
    task automatic conv_one;
        @(posedge clk_sys) soft_trigger <= 1'b1;
        @(posedge clk_sys) soft_trigger <= 1'b0;
        for (int k = 0; k < 40 && conv_done !== 1'b1; k++) @(negedge clk_sys);
        chk("busy", 1, status.busy);
        tick(4);
    endtask
    // low byte is stored first, the high byte loads the pair
    task automatic tw(input logic [1:0] ch, input logic [15:0] v);
        @(posedge clk_sys);
        timer_channel_index <= ch;
        timer_write <= 1'b1;
        timer_byte_high <= 1'b0;
        timer_write_byte <= v[7:0];
        @(posedge clk_sys);
        timer_byte_high <= 1'b1;
        timer_write_byte <= v[15:8];
        @(posedge clk_sys) timer_write <= 1'b0;
    endtask
    task automatic clr;
        @(posedge clk_sys) irq_clear <= 1'b1;
        @(posedge clk_sys) irq_clear <= 1'b0;
        tick(2);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        tick(1);
        chk("reset", 32'h8, status);
        chk("out_rst", 1, counter_out);
        foreach (ROWS[i]) begin
            @(posedge clk_sys) first_irq_source_select <= ROWS[i].src;
            conv_one();
            chk("irq1", ROWS[i].irq, first_interrupt_line);
            @(posedge clk_sys) result_read <= 1'b1;
            @(posedge clk_sys) result_read <= 1'b0;
            tick(1);
            chk("word", ROWS[i].word, result_word);
            chk("valid", 1, result_valid);
            clr();
        end
        $display("test rows done");
        @(posedge clk_sys) first_irq_source_select <= AACQ_IRQ1_HALF;
        repeat (20) conv_one();
        chk("full", 32'h6, status);
        chk("irq1h", 1, first_interrupt_line);
        @(posedge clk_sys) fifo_reset <= 1'b1;
        @(posedge clk_sys) fifo_reset <= 1'b0;
        tick(1);
        chk("flush", 32'h8, status);
        first_irq_source_select <= AACQ_IRQ_OFF;
        clr();
        $display("test fill done");
        second_irq_source_select <= AACQ_IRQ2_EXTERNAL;
        @(posedge clk_sys) ext_irq_in <= 1'b1;
        tick(8);
        chk("irq2x", 1, second_interrupt_line);
        ext_irq_in <= 1'b0;
        tick(6);
        chk("irq2hold", 1, second_interrupt_line);
        clr();
        chk("irq2clr", 0, second_interrupt_line);
        second_irq_source_select <= AACQ_IRQ2_PACER;
        tw(AACQ_TMR_PACER_A, 16'h0005);
        tw(AACQ_TMR_PACER_B, 16'h0005);
        @(posedge clk_sys) pacer_select <= 1'b1;
        for (int k = 0; k < 200 && conv_start !== 1'b1; k++) @(negedge clk_sys);
        chk("pacer", 1, conv_start);
        tick(3);
        chk("irq2p", 1, second_interrupt_line);
        tw(AACQ_TMR_PACER_A, 16'h0000);
        tick(30);
        n = 0;
        repeat (100) begin
            tick(1);
            if (conv_start === 1'b1) n++;
        end
        chk("stopped", 0, n);
        tw(AACQ_TMR_PACER_B, 16'h1234);
        @(posedge clk_sys) timer_read <= 1'b1;
        @(posedge clk_sys) timer_read <= 1'b0;
        tick(1);
        chk("tmr_byte", 32'h34, timer_read_byte);
        $display("test pacer done");
        for (int m = 0; m < 6; m++) begin
            @(posedge clk_sys);
            counter_operating_mode <= 3'(m);
            general_counter_value <= 16'h00C8;
            counter_start <= 1'b1;
            @(posedge clk_sys) counter_start <= 1'b0;
            tick(6);
            if (m == 0) chk("count", 1, counter_readback < 16'h00C8 && counter_readback > 16'h00B0);
            if (m == 0) chk("out0", 0, counter_out);
            @(posedge clk_sys) counter_stop <= 1'b1;
            @(posedge clk_sys) counter_stop <= 1'b0;
            tick(3);
            chk("stop_out", 1, counter_out);
            chk("stop_cnt", 0, counter_readback);
        end
        $display("test counter done");
        tally_and_finish();
    end
    // watchdog: the sequence needs under 5000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end
endmodule
